/* File: dv/hpd_table_model.sv */
// memory model holding software-built 1GB directory-pointer entries
`timescale 1ns/1ps
module hpd_table_model (
  input wire logic [2:0] sel, // entry index
  output logic [63:0] entry // entry read from memory
);
  always_comb
  begin
    case (sel)
      3'h0: entry = 64'h7ff0_0041_4000_0b87;
      3'h1: entry = 64'h8000_0001_4000_0087;
      3'h2: entry = 64'h0000_0001_4000_0083;
      3'h3: entry = 64'h0000_0001_4000_0085;
      3'h4: entry = 64'h0000_2000_4000_0087;
      // broken entries, only fetched by the fault tests
      3'h5: entry = 64'h0000_0001_4000_0086;
      3'h6: entry = 64'h0000_0001_4000_2087;
      default: entry = 64'h0000_0001_4000_0007;
    endcase
  end
endmodule

/* File: dv/hpd_top_assertions.sv */
// assertions on the axi4-lite ports of the entry decoder
`timescale 1ns/1ps
`include "hpd_consts.svh"
module hpd_top_assertions (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic [31:0] s_axi_araddr, // ar addr
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic [1:0] s_axi_rresp, // r resp
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready // r ready
);
  logic [31:0] ar_q;
  logic [31:0] ar_d;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ********************
  // address of the read under way
  // ********************
  always_comb
  begin
    ar_d = ar_q;
    if (s_axi_arvalid && s_axi_arready)
      ar_d = s_axi_araddr;
  end
  always_ff @(posedge aclk)
    ar_q <= ar_d;
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_rd_stat;
    s_axi_rvalid && ar_q == `HPD_ADDR_STAT && s_axi_rdata[12];
  endsequence
  // ********************
  // checks
  // ********************
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  write_answer_a: assert property (s_wr_taken |-> ##[1:8] s_axi_bvalid)
    else $error("no write response");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |->
    ##[1:4] s_axi_rvalid) else $error("no read data");
  bad_read_a: assert property (s_axi_rvalid && ar_q > `HPD_ADDR_NHI |->
    s_axi_rresp == `HPD_RESP_ERR) else $error("unmapped read accepted");
  grant_clean_a:
    assert property (s_rd_stat ##0 s_axi_rdata[7] |->
    s_axi_rdata[11:8] == 4'h0) else $error("grant with denial");
  flags_need_grant_a:
    assert property (s_rd_stat ##0 !s_axi_rdata[7] |->
    s_axi_rdata[2:0] == 3'h0) else $error("flag set without grant");
  dirty_write_ok_a:
    assert property (s_rd_stat ##0 s_axi_rdata[1] |-> !s_axi_rdata[8])
    else $error("dirty on denied write");
  base_high_a:
    assert property (s_axi_rvalid && ar_q == `HPD_ADDR_BHI |->
    s_axi_rdata[31:14] == 18'h0_0000) else $error("base too wide");
  base_low_a:
    assert property (s_axi_rvalid && ar_q == `HPD_ADDR_BLO |->
    s_axi_rdata[29:0] == 30'h0000_0000) else $error("base not aligned");
endmodule
bind hpd_top hpd_top_assertions i_hpd_top_assertions (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

/* File: dv/huge_page_dir_entry_decoder_test.sv */
// testbench for the entry decoder through its axi4-lite port
`timescale 1ns/1ps
`include "hpd_consts.svh"
module huge_page_dir_entry_decoder_test;
  import hpd_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0000_0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_araddr = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0] sel = 3'h0;
  logic [63:0] tbl;
  int failures = 0;
  int checks_done = 0;
  always #25 aclk = ~aclk;
  hpd_top i_hpd_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  hpd_table_model i_hpd_table_model (.sel(sel), .entry(tbl));
  // ********************
  // bus and check tasks
  // ********************
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d,
    output logic [1:0] rsp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] d,
    output logic [1:0] rsp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic run(input logic [2:0] k, input logic [63:0] orr,
    input hpd_ctx_t c, input hpd_req_t r);
    logic [63:0] e;
    logic [31:0] d;
    logic [31:0] h;
    logic [1:0] rs;
    hpd_res_t x;
    int w;
    int n;
    sel = k;
    #1;
    e = tbl | orr;
    w = c.server_mode ? `HPD_HAW_SERVER : `HPD_HAW_CLIENT;
    x = '0;
    x.fault = !e[0] || !e[7] || (e[51:0] >> w) != 0 || e[29:13] != 0;
    x.deny_exec = c.no_execute_enable & e[63] & r.is_exec;
    x.deny_user = !e[2] & r.is_user;
    x.deny_write = r.is_write & !e[1] & (r.is_user | c.write_protect_enable);
    x.grant = !(x.fault | x.deny_exec | x.deny_user | x.deny_write);
    x.guest_phys = c.nested_translation_enable;
    x.mem_type_idx = {e[12], e[4], e[3]};
    x.set_accessed = x.grant & !e[5];
    x.set_dirty = x.grant & r.is_write & !e[6];
    x.set_ext_access = x.grant & c.extended_access_flag_enable & !e[10];
    axw(`HPD_ADDR_CTRL, {27'h000_0000, c}, rs);
    axw(`HPD_ADDR_ELO, e[31:0], rs);
    axw(`HPD_ADDR_EHI, e[63:32], rs);
    axw(`HPD_ADDR_REQ, {29'h0000_0000, r}, rs);
    d = '0;
    n = 0;
    while (d[12] !== 1'b1 && n < 8)
    begin
      axr(`HPD_ADDR_STAT, d, rs);
      n++;
    end
    if (x.fault)
      chk({d[12:11], d[7], d[2:0]}, {1'b1, x.fault, x.grant, x[2:0]});
    else
      chk(d[12:0], {1'b1, x});
    if (!x.fault)
    begin
      axr(`HPD_ADDR_BLO, d, rs);
      axr(`HPD_ADDR_BHI, h, rs);
      chk({h, d}, e & ((64'h1 << w) - 1) & ~64'h0000_0000_3fff_ffff);
      axr(`HPD_ADDR_NLO, d, rs);
      axr(`HPD_ADDR_NHI, h, rs);
      chk({h, d}, e | {53'h0, x.set_ext_access, 3'h0, x.set_dirty,
        x.set_accessed, 5'h0});
    end
    $display("test entry %0d done at %0t", k, $time);
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ********************
  // tests
  // ********************
  initial
  begin
    logic [31:0] d;
    logic [1:0] rs;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      run(3'h0, {51'h0, i[2], 7'h0, i[1:0], 3'h0}, 5'h00, 3'h1);
    run(3'h1, '0, 5'h10, 3'h5);
    run(3'h1, '0, 5'h00, 3'h5);
    run(3'h2, '0, 5'h00, 3'h1);
    run(3'h2, '0, 5'h00, 3'h0);
    run(3'h3, '0, 5'h00, 3'h3);
    run(3'h3, '0, 5'h00, 3'h2);
    run(3'h3, '0, 5'h04, 3'h2);
    run(3'h0, '0, 5'h02, 3'h3);
    run(3'h0, 64'h0000_0000_0000_0460, 5'h02, 3'h2);
    run(3'h0, 64'h0000_0000_0000_0400, 5'h00, 3'h1);
    run(3'h0, '0, 5'h08, 3'h1);
    run(3'h4, '0, 5'h01, 3'h1);
    run(3'h4, '0, 5'h00, 3'h1);
    for (int k = 5; k < 8; k++)
      run(k[2:0], '0, 5'h00, 3'h1);
    axw(32'h0000_0040, 32'h0000_0001, rs);
    chk(rs, `HPD_RESP_ERR);
    axr(32'h0000_0100, d, rs);
    chk(rs, `HPD_RESP_ERR);
    axr(`HPD_ADDR_CTRL, d, rs);
    chk({rs, d}, {`HPD_RESP_OK, 32'h0000_0000});
    $display("test bus errors done at %0t", $time);
    end_of_test();
  end
  initial
  begin
    #2000000;
    failures++;
    $display("unexpected at %0t: timeout", $time);
    end_of_test();
  end
endmodule

/* File: logic/hpd_decode.sv */
// combinational check of one 1GB directory-pointer entry
`timescale 1ns/1ps
`include "hpd_consts.svh"
module hpd_decode
  import hpd_pkg::*;
#(
  parameter int ENTRY_W = 64
)(
  input wire logic [ENTRY_W-1:0] entry, // entry as read from memory
  input wire hpd_ctx_t ctx, // governing context enables
  input wire hpd_req_t req, // request kind
  output logic [ENTRY_W-1:0] base, // page base, low 30 bits zero
  output hpd_res_t res // decode result
);
  logic [ENTRY_W-1:0] hi_mask;
  logic rsv_bad;
  logic present;
  logic [5:0] host_address_width;
  always_comb
  begin
    host_address_width = ctx.server_mode ? 6'(`HPD_HAW_SERVER) : 6'(`HPD_HAW_CLIENT);
    // reserved range 51 down to host width
    hi_mask = '0;
    for (int i = 0; i <= `HPD_RSV_HI; i++)
    begin
      if (i >= int'(host_address_width))
      begin
        hi_mask[i] = 1'b1;
      end
    end
    rsv_bad = |(entry & hi_mask)
      | |entry[`HPD_RSV2_HI:`HPD_RSV2_LO]
      | ~entry[`HPD_BIT_PS];
    present = entry[`HPD_BIT_P];
    // bits 62:52, 11, 9 and global bit 8 not looked at
    base = '0;
    for (int i = `HPD_BASE_LO; i <= `HPD_RSV_HI; i++)
    begin
      if (i < int'(host_address_width))
      begin
        base[i] = entry[i];
      end
    end
    res.fault = ~present | rsv_bad;
    res.deny_exec = req.is_exec & ctx.no_execute_enable
      & entry[`HPD_BIT_XD];
    res.deny_user = req.is_user & ~entry[`HPD_BIT_US];
    res.deny_write = req.is_write & ~entry[`HPD_BIT_RW]
      & (req.is_user | ctx.write_protect_enable);
    res.grant = ~res.fault & ~res.deny_exec & ~res.deny_user
      & ~res.deny_write;
    res.guest_phys = ctx.nested_translation_enable;
    res.mem_type_idx = {entry[`HPD_BIT_PAT], entry[`HPD_BIT_PCD],
      entry[`HPD_BIT_PWT]};
    res.set_accessed = res.grant & ~entry[`HPD_BIT_A];
    res.set_dirty = res.grant & req.is_write
      & ~entry[`HPD_BIT_D];
    res.set_ext_access = res.grant & ctx.extended_access_flag_enable
      & ~entry[`HPD_BIT_EA];
  end
endmodule

/* File: logic/hpd_top.sv */
// axi4-lite wrapper: entry decode, checks and flag write-back
`timescale 1ns/1ps
`include "hpd_consts.svh"
module hpd_top
  import hpd_pkg::*;
(
  input wire logic aclk, // 20 MHz clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  typedef enum logic [2:0] {
    HPD_W_IDLE = 3'b001,
    HPD_W_RESP = 3'b010,
    HPD_W_HOLD = 3'b100
  } hpd_wst_t;

  // ************************************
  // register state
  // ************************************
  hpd_wst_t wst_q, wst_d;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d;
  logic bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  hpd_ctx_t ctx_q, ctx_d;
  hpd_req_t req_q, req_d;
  logic [63:0] entry_q, entry_d;
  logic [63:0] base_q, base_d;
  hpd_res_t res_q, res_d;
  logic [63:0] new_entry_q, new_entry_d;
  logic done_q, done_d;
  logic [63:0] base_c;
  hpd_res_t res_c;
  logic awready_q, wready_q;
  logic [31:0] ctx_w;

  hpd_decode #(
    .ENTRY_W(64)
  ) u_dec (
    .entry(entry_q),
    .ctx(ctx_q),
    .req(req_q),
    .base(base_c),
    .res(res_c)
  );

  function automatic logic [31:0] hpd_merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (st[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ************************************
  // write channel and register updates
  // ************************************
  logic wr_fire;
  logic [63:0] upd;
  always_comb
  begin
    wst_d = wst_q;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bresp_d = bresp_q;
    bvalid_d = bvalid_q;
    ctx_d = ctx_q;
    req_d = req_q;
    entry_d = entry_q;
    base_d = base_q;
    res_d = res_q;
    new_entry_d = new_entry_q;
    done_d = done_q;
    wr_fire = 1'b0;
    upd = entry_q;
    ctx_w = 32'h0000_0000;
    case (wst_q)
      HPD_W_IDLE:
      begin
        if (s_axi_awvalid && awready_q)
        begin
          aw_got_d = 1'b1;
          awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
          w_got_d = 1'b1;
          wdata_d = s_axi_wdata;
          wstrb_d = s_axi_wstrb;
        end
        if (aw_got_q && w_got_q)
        begin
          wr_fire = 1'b1;
          wst_d = HPD_W_RESP;
        end
      end
      HPD_W_RESP:
      begin
        bvalid_d = 1'b1;
        wst_d = HPD_W_HOLD;
      end
      HPD_W_HOLD:
      begin
        if (s_axi_bready)
        begin
          bvalid_d = 1'b0;
          aw_got_d = 1'b0;
          w_got_d = 1'b0;
          wst_d = HPD_W_IDLE;
        end
      end
      default:
      begin
        wst_d = HPD_W_IDLE;
      end
    endcase
    if (wr_fire)
    begin
      bresp_d = `HPD_RESP_OK;
      if (awaddr_q[7:0] == `HPD_ADDR_CTRL)
      begin
        ctx_w = hpd_merge({27'h000_0000, ctx_q}, wdata_q, wstrb_q);
        ctx_d = hpd_ctx_t'(ctx_w[4:0]);
      end
      else if (awaddr_q[7:0] == `HPD_ADDR_ELO)
      begin
        entry_d[31:0] = hpd_merge(entry_q[31:0], wdata_q, wstrb_q);
      end
      else if (awaddr_q[7:0] == `HPD_ADDR_EHI)
      begin
        entry_d[63:32] = hpd_merge(entry_q[63:32], wdata_q, wstrb_q);
      end
      else if (awaddr_q[7:0] == `HPD_ADDR_REQ)
      begin
        // writing the request kind launches one translation
        req_d = hpd_req_t'(wdata_q[2:0]);
        done_d = 1'b0;
      end
      else
      begin
        bresp_d = `HPD_RESP_ERR;
      end
      if (awaddr_q[31:8] != 24'h00_0000)
      begin
        bresp_d = `HPD_RESP_ERR;
      end
    end
    // latch decode one cycle after request capture
    if (wst_q == HPD_W_RESP)
    begin
      base_d = base_c;
      res_d = res_c;
      if (res_c.set_accessed)
      begin
        upd[`HPD_BIT_A] = 1'b1;
      end
      if (res_c.set_dirty)
      begin
        upd[`HPD_BIT_D] = 1'b1;
      end
      if (res_c.set_ext_access)
      begin
        upd[`HPD_BIT_EA] = 1'b1;
      end
      new_entry_d = upd;
      done_d = 1'b1;
    end
  end

  // ************************************
  // read channel
  // ************************************
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb
  begin
    arready_d = 1'b0;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    if (s_axi_araddr[31:8] != 24'h00_0000)
    begin
      rd_ok = 1'b0;
    end
    else if (s_axi_araddr[7:0] == `HPD_ADDR_CTRL)
    begin
      rd_val = {27'h000_0000, ctx_q};
    end
    else if (s_axi_araddr[7:0] == `HPD_ADDR_ELO)
    begin
      rd_val = entry_q[31:0];
    end
    else if (s_axi_araddr[7:0] == `HPD_ADDR_EHI)
    begin
      rd_val = entry_q[63:32];
    end
    else if (s_axi_araddr[7:0] == `HPD_ADDR_REQ)
    begin
      rd_val = {29'h0000_0000, req_q};
    end
    else if (s_axi_araddr[7:0] == `HPD_ADDR_STAT)
    begin
      rd_val = {19'h0_0000, done_q, res_q};
    end
    else if (s_axi_araddr[7:0] == `HPD_ADDR_BLO)
    begin
      rd_val = base_q[31:0];
    end
    else if (s_axi_araddr[7:0] == `HPD_ADDR_BHI)
    begin
      rd_val = base_q[63:32];
    end
    else if (s_axi_araddr[7:0] == `HPD_ADDR_NLO)
    begin
      rd_val = new_entry_q[31:0];
    end
    else if (s_axi_araddr[7:0] == `HPD_ADDR_NHI)
    begin
      rd_val = new_entry_q[63:32];
    end
    else
    begin
      rd_ok = 1'b0;
    end
    if (rvalid_q)
    begin
      if (s_axi_rready)
      begin
        rvalid_d = 1'b0;
      end
    end
    else if (s_axi_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rdata_d = rd_val;
      rresp_d = rd_ok ? `HPD_RESP_OK : `HPD_RESP_ERR;
    end
    // address taken only while no read data waits
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wst_q <= HPD_W_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= 2'b00;
      bvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
      ctx_q <= '0;
      req_q <= '0;
      entry_q <= 64'h0000_0000_0000_0000;
      base_q <= 64'h0000_0000_0000_0000;
      res_q <= '0;
      new_entry_q <= 64'h0000_0000_0000_0000;
      done_q <= 1'b0;
    end
    else
    begin
      wst_q <= wst_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      bvalid_q <= bvalid_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctx_q <= ctx_d;
      req_q <= req_d;
      entry_q <= entry_d;
      base_q <= base_d;
      res_q <= res_d;
      new_entry_q <= new_entry_d;
      done_q <= done_d;
    end
  end

  // ready held high while idle and not yet taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end
    else
    begin
      awready_q <= (wst_d == HPD_W_IDLE) && !aw_got_d;
      wready_q <= (wst_d == HPD_W_IDLE) && !w_got_d;
    end
  end
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

/* File: pkg/hpd_consts.svh */
// constants for the 1GB directory-pointer entry decoder
`ifndef HPD_CONSTS_SVH
`define HPD_CONSTS_SVH
`define HPD_HAW_CLIENT 39
`define HPD_HAW_SERVER 46
`define HPD_BIT_XD 63
`define HPD_RSV_HI 51
`define HPD_BASE_LO 30
`define HPD_RSV2_HI 29
`define HPD_RSV2_LO 13
`define HPD_BIT_PAT 12
`define HPD_BIT_EA 10
`define HPD_BIT_PS 7
`define HPD_BIT_D 6
`define HPD_BIT_A 5
`define HPD_BIT_PCD 4
`define HPD_BIT_PWT 3
`define HPD_BIT_US 2
`define HPD_BIT_RW 1
`define HPD_BIT_P 0
`define HPD_ADDR_CTRL 32'h0000_0000
`define HPD_ADDR_ELO 32'h0000_0004
`define HPD_ADDR_EHI 32'h0000_0008
`define HPD_ADDR_REQ 32'h0000_000C
`define HPD_ADDR_STAT 32'h0000_0010
`define HPD_ADDR_BLO 32'h0000_0014
`define HPD_ADDR_BHI 32'h0000_0018
`define HPD_ADDR_NLO 32'h0000_001C
`define HPD_ADDR_NHI 32'h0000_0020
`define HPD_RESP_OK 2'b00
`define HPD_RESP_ERR 2'b10
`endif

/* File: pkg/hpd_pkg.sv */
// types for the 1GB directory-pointer entry decoder
package hpd_pkg;
  typedef struct packed {
    logic no_execute_enable;
    logic nested_translation_enable;
    logic write_protect_enable;
    logic extended_access_flag_enable;
    logic server_mode;
  } hpd_ctx_t;
  typedef struct packed {
    logic is_exec;
    logic is_write;
    logic is_user;
  } hpd_req_t;
  typedef struct packed {
    logic fault;
    logic deny_exec;
    logic deny_user;
    logic deny_write;
    logic grant;
    logic guest_phys;
    logic [2:0] mem_type_idx;
    logic set_accessed;
    logic set_dirty;
    logic set_ext_access;
  } hpd_res_t;
endpackage
